// ### hdl/nvsp_pkg.sv
// shared constants and carrier types for the serial nv memory port
package nvsp_pkg;
  localparam int unsigned SCK_MAX_HZ = 20_000_000;
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_DC_W  = 5;
  localparam int unsigned MEM_DEPTH  = 2048;

  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;

  localparam int unsigned SR_WEL_POS  = 1;
  localparam int unsigned SR_BP0_POS  = 2;
  localparam int unsigned SR_BP1_POS  = 3;
  localparam int unsigned SR_GEN_POS  = 7;
  localparam logic [7:0]  SR_WR_MASK  = 8'h8C;
  localparam logic [7:0]  SR_RST      = 8'h00;
  localparam logic [2:0]  BIT_RST     = 3'h7;
  localparam logic [3:0]  ADDR_BITS_HI = 4'h0;

  typedef enum logic [2:0] {
    ST_OPC  = 3'b000,
    ST_ADH  = 3'b001,
    ST_ADL  = 3'b011,
    ST_DATA = 3'b010,
    ST_SRWR = 3'b110,
    ST_RDO  = 3'b111,
    ST_IGN  = 3'b101
  } nvsp_state_t;

  // one array write request, link domain to system domain
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } nvsp_wreq_t;

  // pin group at the serial port
  typedef struct packed {
    logic cs_n;
    logic si;
    logic hold_n;
    logic guard_n;
  } nvsp_pins_t;
endpackage

// ### hdl/nvsp_sync.sv
// two flop level synchroniser
`timescale 1ns/1ns
module nvsp_sync
  import nvsp_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // clock
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         ce_in,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } nvsp_sync_st_t;
  nvsp_sync_st_t st_r;
  nvsp_sync_st_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  assign q_out = st_r.s2;
endmodule // nvsp_sync

// ### hdl/nvsp_mem.sv
// byte array, written from the system domain, read combinationally
`timescale 1ns/1ns
module nvsp_mem
  import nvsp_pkg::*;
#(
  parameter int unsigned AW    = ADDR_W,
  parameter int unsigned DW    = DATA_W,
  parameter int unsigned DEPTH = MEM_DEPTH
) (
  // clock
  input  wire logic          clk_in,
  input  wire logic          ce_in,
  // write port
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [DW-1:0] wdata_in,
  // read port
  input  wire logic [AW-1:0] raddr_in,
  output logic      [DW-1:0] rdata_out
);
  // nonvolatile contents: no reset on purpose
  logic [DW-1:0] mem_r [DEPTH];

  always_ff @(posedge clk_in) begin
    if (ce_in && we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
  end

  assign rdata_out = mem_r[raddr_in];
endmodule // nvsp_mem

// ### hdl/nvsp_port.sv
// serial nv memory slave port: link shifter, status and array commit
// Overview of operation
// - select low means active
// - select high: standby, output released
// - input sampled on rising clock only
// - output changes on falling clock
// - output driven only for read data
// - clock may stop; state held
// - clock seen only while selected
// - guard pin low plus enable blocks status write
// - pause low suspends operation
// - paused: clock and select ignored
// - each byte committed at once
// - works in mode 0 and 3
// - 2K bytes of eight bits
// - block protect quarter, half, all; write disable
// - first byte after select is command
// - unknown command ignored until reselect
// - all fields most significant bit first
// - two address bytes, low 11 bits used
`timescale 1ns/1ns
module nvsp_port
  import nvsp_pkg::*;
#(
  parameter int unsigned AW = ADDR_W,
  parameter int unsigned DW = DATA_W
) (
  // system clock
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic ce_in,
  // serial link
  input  wire logic sck_in,
  input  wire logic cs_n_in,
  input  wire logic si_in,
  input  wire logic hold_n_in,
  input  wire logic guard_n_in,
  output logic      so_out,
  output logic      so_oe_n_out,
  // status view
  output logic [7:0] status_out
);
  // link domain state, clocked by sck; all but addr, wreq and sval cleared by select high
  typedef struct packed {
    nvsp_state_t       st;
    logic [2:0]        bitn;
    logic [7:0]        sh;
    logic [15:0]       addr;
    logic [7:0]        cmd;
    logic              wtog;
    nvsp_wreq_t        wreq;
    logic              stog;
    logic [7:0]        sval;
    logic              wel_set;
    logic              wel_clr;
  } nvsp_link_t;

  // system domain state
  typedef struct packed {
    logic [7:0] sr;
    logic [2:0] wtog_s;
    logic [2:0] stog_s;
    logic [2:0] etog_s;
    logic       so;
    logic       oe_n;
    logic [7:0] st_o;
  } nvsp_sys_t;

  nvsp_link_t lk_r;
  nvsp_link_t lk_nxt;
  nvsp_sys_t  sy_r;
  nvsp_sys_t  sy_nxt;

  logic       so_fall_r;
  logic       oe_fall_r;
  logic       sck_g;
  logic       link_rst;
  logic       arm_r;
  logic       lo_sel;
  logic       sel_s;
  logic       hold_s;
  logic       guard_s;
  logic [7:0] rd_byte;
  logic [7:0] sr_view;
  logic       mem_we;
  logic       in_prot;
  logic [1:0] bp;

  // paused: select edges do not end the frame
  assign link_rst = cs_n_in & hold_n_in;

  // clock low while selected arms the gate; in mode 3 select
  // falls with the clock high, which would otherwise look like
  // a first rising edge and shift one bit too many
  assign lo_sel   = ~sck_in & ~cs_n_in;

  // reads the pin, not link_rst, so select falling cannot race
  always_ff @(posedge lo_sel or posedge link_rst) begin
    if (cs_n_in) begin
      arm_r <= 1'b0;
    end else begin
      arm_r <= 1'b1;
    end
  end

  // first rise after an armed low
  assign sck_g = sck_in & ~cs_n_in & hold_n_in & arm_r;

  // status bits are quasi static during a frame; mem read is async
  assign sr_view = sy_r.sr;
  assign bp      = sy_r.sr[SR_BP1_POS:SR_BP0_POS];

  nvsp_mem #(
    .AW    (AW),
    .DW    (DW),
    .DEPTH (MEM_DEPTH)
  ) u_mem (
    .clk_in    (clk_in),
    .ce_in     (ce_in),
    .we_in     (mem_we),
    .waddr_in  (lk_r.wreq.addr),
    .wdata_in  (lk_r.wreq.data),
    .raddr_in  (lk_r.addr[AW-1:0]),
    .rdata_out (rd_byte)
  );

  always_comb begin
    lk_nxt      = lk_r;
    lk_nxt.bitn = lk_r.bitn - 3'd1;
    lk_nxt.sh   = {lk_r.sh[6:0], si_in};
    case (lk_r.st)
      ST_OPC: begin
        if (lk_r.bitn == 3'd0) begin
          lk_nxt.cmd = {lk_r.sh[6:0], si_in};
          case ({lk_r.sh[6:0], si_in})
            OP_WREN:  begin
              lk_nxt.wel_set = ~lk_r.wel_set;
              lk_nxt.st      = ST_IGN;
            end
            OP_WRDI:  begin
              lk_nxt.wel_clr = ~lk_r.wel_clr;
              lk_nxt.st      = ST_IGN;
            end
            OP_RDSR:  lk_nxt.st = ST_RDO;
            OP_WRSR:  lk_nxt.st = ST_SRWR;
            OP_READ:  lk_nxt.st = ST_ADH;
            OP_WRITE: lk_nxt.st = ST_ADH;
            default:  lk_nxt.st = ST_IGN;
          endcase
        end
      end
      ST_ADH: begin
        if (lk_r.bitn == 3'd0) begin
          lk_nxt.st = ST_ADL;
        end
      end
      ST_ADL: begin
        if (lk_r.bitn == 3'd0) begin
          lk_nxt.addr = {lk_r.sh[7:0], lk_r.sh[6:0], si_in};
          lk_nxt.addr[15:AW] = '0;
          lk_nxt.addr[7:0] = {lk_r.sh[6:0], si_in};
          lk_nxt.addr[AW-1:8] = lk_r.addr[AW-1:8];
          lk_nxt.st = (lk_r.cmd == OP_READ) ? ST_RDO : ST_DATA;
        end else if (lk_r.bitn == 3'd7) begin
          lk_nxt.addr[AW-1:8] = lk_r.sh[AW-9:0];
        end
      end
      ST_DATA: begin
        if (lk_r.bitn == 3'd0) begin
          lk_nxt.wreq.addr = lk_r.addr[AW-1:0];
          lk_nxt.wreq.data = {lk_r.sh[6:0], si_in};
          lk_nxt.wtog      = ~lk_r.wtog;
          lk_nxt.addr      = {5'h00, lk_r.addr[AW-1:0] + 11'd1};
        end
      end
      ST_SRWR: begin
        if (lk_r.bitn == 3'd0) begin
          lk_nxt.sval = {lk_r.sh[6:0], si_in};
          lk_nxt.stog = ~lk_r.stog;
          lk_nxt.st   = ST_IGN;
        end
      end
      ST_RDO: begin
        if (lk_r.bitn == 3'd0 && lk_r.cmd == OP_READ) begin
          lk_nxt.addr = {5'h00, lk_r.addr[AW-1:0] + 11'd1};
        end
      end
      ST_IGN:  lk_nxt.st = ST_IGN;
      default: lk_nxt.st = ST_IGN;
    endcase
  end

  // edge use same in both modes
  always_ff @(posedge sck_g or posedge link_rst) begin
    if (link_rst) begin
      lk_r.st      <= ST_OPC;
      lk_r.bitn    <= BIT_RST;
      lk_r.sh      <= '0;
      lk_r.cmd     <= '0;
      // toggles restart at zero each frame; system side follows
      lk_r.wtog    <= 1'b0;
      lk_r.stog    <= 1'b0;
      lk_r.wel_set <= 1'b0;
      lk_r.wel_clr <= 1'b0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  always_ff @(negedge sck_g or posedge link_rst) begin
    if (link_rst) begin
      so_fall_r <= 1'b0;
      oe_fall_r <= 1'b0;
    end else begin
      oe_fall_r <= (lk_r.st == ST_RDO);
      so_fall_r <= (lk_r.cmd == OP_RDSR) ? sr_view[lk_r.bitn]
                                         : rd_byte[lk_r.bitn];
    end
  end

  nvsp_sync #(
    .W (3)
  ) u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .d_in       ({~cs_n_in, hold_n_in, guard_n_in}),
    .q_out      ({sel_s, hold_s, guard_s})
  );

  // write toggle crossing; payload stable long before toggle lands
  // deselect drops the toggle; sel_s masks that false event
  assign mem_we = sel_s && (sy_r.wtog_s[2] != sy_r.wtog_s[1]) &&
                  ~in_prot;

  always_comb begin
    case (bp)
      2'b01:   in_prot = lk_r.wreq.addr[AW-1:AW-2] == 2'b11;
      2'b10:   in_prot = lk_r.wreq.addr[AW-1];
      2'b11:   in_prot = 1'b1;
      default: in_prot = 1'b0;
    endcase
    in_prot = in_prot | ~sy_r.sr[SR_WEL_POS];
  end

  always_comb begin
    sy_nxt        = sy_r;
    sy_nxt.wtog_s = {sy_r.wtog_s[1:0], lk_r.wtog};
    sy_nxt.stog_s = {sy_r.stog_s[1:0], lk_r.stog};
    sy_nxt.etog_s = {sy_r.etog_s[1:0], lk_r.wel_set ^ lk_r.wel_clr};
    if (sel_s && sy_r.etog_s[2] != sy_r.etog_s[1]) begin
      sy_nxt.sr[SR_WEL_POS] = lk_r.wel_set & ~lk_r.wel_clr;
    end
    if (sel_s && sy_r.stog_s[2] != sy_r.stog_s[1] &&
        sy_r.sr[SR_WEL_POS] && !(~guard_s && sy_r.sr[SR_GEN_POS])) begin
      sy_nxt.sr = (sy_r.sr & ~SR_WR_MASK) | (lk_r.sval & SR_WR_MASK);
    end
    // link toggles fall to zero on deselect; follow them quietly
    if (!sel_s) begin
      sy_nxt.wtog_s = '0;
      sy_nxt.stog_s = '0;
      sy_nxt.etog_s = '0;
    end
    sy_nxt.oe_n = ~(sel_s & hold_s & oe_fall_r);
    sy_nxt.so   = so_fall_r;
    sy_nxt.st_o = sy_r.sr;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sy_r      <= '0;
      sy_r.oe_n <= 1'b1;
      sy_r.sr   <= SR_RST;
    end else if (ce_in) begin
      sy_r <= sy_nxt;
    end
  end

  assign so_out      = sy_r.so;
  assign so_oe_n_out = sy_r.oe_n;
  assign status_out  = sy_r.st_o;
endmodule // nvsp_port

// ### test/nvsp_port_assertions.sv
// pin level assertions for the serial nv memory port
`timescale 1ns/1ns
module nvsp_chk
  import nvsp_pkg::*;
(
  // system clock
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  // serial link
  input wire logic       sck_in,
  input wire logic       cs_n_in,
  input wire logic       hold_n_in,
  input wire logic       guard_n_in,
  input wire logic       so_out,
  input wire logic       so_oe_n_out,
  input wire logic [7:0] status_out
);
  logic       sck_r;
  logic [2:0] quiet_r;
  logic [2:0] guard_r;
  logic [3:0] desel_r;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // saturating counts, so long idle spans stay cheap
  always_ff @(posedge clk_in) begin
    sck_r   <= sck_in;
    quiet_r <= (sck_in != sck_r) ? 3'h0 : quiet_r + 3'(quiet_r != 3'h7);
    guard_r <= guard_n_in ? 3'h0 : guard_r + 3'(guard_r != 3'h7);
    desel_r <= (!cs_n_in || sys_rst_in) ? 4'h0 :
               desel_r + 4'(desel_r != 4'hF);
  end
  property p_rst;
    disable iff (1'b0) sys_rst_in |=> so_oe_n_out && status_out == SR_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_desel;
    cs_n_in [*6] |-> so_oe_n_out;
  endproperty
  a_desel: assert property (p_desel) else $error("driving in standby");
  property p_hold;
    !hold_n_in [*6] |-> so_oe_n_out;
  endproperty
  a_hold: assert property (p_hold) else $error("driving while paused");
  property p_drive;
    $fell(so_oe_n_out) |-> !cs_n_in && hold_n_in;
  endproperty
  a_drive: assert property (p_drive) else $error("drive unselected");
  property p_fall;
    !so_oe_n_out && !$past(so_oe_n_out) && $changed(so_out)
      |-> !sck_r && quiet_r <= 3'h5;
  endproperty
  a_fall: assert property (p_fall) else $error("output not on fall");
  property p_quiet;
    quiet_r == 3'h7 && !so_oe_n_out && !$past(so_oe_n_out)
      |-> $stable(so_out);
  endproperty
  a_quiet: assert property (p_quiet) else $error("output moved idle");
  property p_guard;
    guard_r == 3'h7 && status_out[SR_GEN_POS]
      |=> (status_out & SR_WR_MASK) == ($past(status_out) & SR_WR_MASK);
  endproperty
  a_guard: assert property (p_guard) else $error("guarded write");
  property p_idle_sr;
    desel_r == 4'hF |-> $stable(status_out);
  endproperty
  a_idle_sr: assert property (p_idle_sr) else $error("status moved");
endmodule // nvsp_chk
bind nvsp_port nvsp_chk nvsp_chk_i (.*);

// ### test/nvsp_master.sv
// spi master model facing the serial port
`timescale 1ns/1ns
module nvsp_master (
  // serial pins
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out,
  output logic      hold_n_out,
  input  wire logic so_in,
  input  wire logic so_oe_n_in
);
  logic mode3_r = 1'b0;
  initial begin
    sck_out    = 1'b0;
    si_out     = 1'b1;
    hold_n_out = 1'b1;
    // late rise gives the port a clean select reset edge
    #1 cs_n_out = 1'b1;
  end
  // fresh select, clock idles per mode
  task automatic sel(input logic m3);
    mode3_r = m3;
    sck_out = m3;
    #62 cs_n_out = 1'b0;
    #63;
  endtask
  task automatic desel();
    #62 cs_n_out = 1'b1;
    // released line shows inverse, not a stale value
    si_out = ~si_out;
    #63;
  endtask
  // msb first, pause moved with clock low
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      input int pz);
    for (int i = 7; i >= 0; i--) begin
      sck_out = 1'b0;
      si_out  = tx[i];
      if (i == pz) begin
        #20 hold_n_out = 1'b0;
        repeat (3) begin
          #30 sck_out = 1'b1;
          cs_n_out = 1'b1;
          #30 sck_out = 1'b0;
          cs_n_out = 1'b0;
        end
        #20 hold_n_out = 1'b1;
      end
      #62 sck_out = 1'b1;
      rx[i] = so_oe_n_in ? 1'bx : so_in;
      #63;
    end
    if (!mode3_r) sck_out = 1'b0;
  endtask
endmodule // nvsp_master

// ### test/nvsp_port_tb_top.sv
// self checking bench for the serial nv memory port
`timescale 1ns/1ns
module nvsp_port_tb_top
  import nvsp_pkg::*;
;
  logic       clk_in, sys_rst_in, ce_in, guard_n_in;
  logic       sck, cs_n, si, hold_n, so, so_oe_n, drove;
  logic [7:0] status;
  logic [7:0] rd[$];
  int         bad_count, comparisons;
  nvsp_port nvsp_port_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .ce_in(ce_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .hold_n_in(hold_n), .guard_n_in(guard_n_in), .so_out(so),
    .so_oe_n_out(so_oe_n), .status_out(status));
  nvsp_master nvsp_master_i (.sck_out(sck), .cs_n_out(cs_n), .si_out(si),
    .hold_n_out(hold_n), .so_in(so), .so_oe_n_in(so_oe_n));
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) if (so_oe_n === 1'b0) drove <= 1'b1;
  task automatic check(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic frame(input logic m3, input logic [7:0] b[$],
                       input int n, input int pz);
    logic [7:0] d;
    nvsp_master_i.sel(m3);
    foreach (b[k]) nvsp_master_i.xfer(b[k], d, 9);
    rd.delete();
    // master never drives the data line back
    repeat (n) begin
      nvsp_master_i.xfer(8'h00, d, pz);
      rd.push_back(d);
      pz = 9;
    end
    nvsp_master_i.desel();
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // high address bits junk, read back at once
  task automatic t_write_read();
    frame(0, '{OP_WREN}, 0, 9);
    check("wel", status & 8'h02, 8'h02);
    frame(0, '{OP_WRITE, 8'hF9, 8'h23, 8'hA5, 8'h3C}, 0, 9);
    frame(1, '{OP_READ, 8'h01, 8'h23}, 2, 3);
    check("rd0", rd[0], 8'hA5);
    check("rd1", rd[1], 8'h3C);
  endtask
  task automatic t_bad();
    drove = 1'b0;
    frame(0, '{8'hFF, OP_READ, 8'h01, 8'h23}, 1, 9);
    check("oe", {7'h0, drove}, 8'h00);
    frame(0, '{OP_WREN}, 0, 9);
    frame(0, '{OP_WRDI}, 0, 9);
    check("wrdi", status & 8'h02, 8'h00);
    frame(0, '{OP_WRITE, 8'h01, 8'h24, 8'h55}, 0, 9);
    frame(0, '{OP_READ, 8'h01, 8'h24}, 1, 9);
    check("nowr", rd[0], 8'h3C);
  endtask
  task automatic t_status();
    frame(0, '{OP_WREN}, 0, 9);
    frame(0, '{OP_WRSR, 8'h8C}, 0, 9);
    check("sr", status & SR_WR_MASK, 8'h8C);
    frame(1, '{OP_RDSR}, 1, 9);
    check("rdsr", rd[0] & SR_WR_MASK, 8'h8C);
    frame(0, '{OP_WREN}, 0, 9);
    frame(0, '{OP_WRITE, 8'h01, 8'h23, 8'h77}, 0, 9);
    @(posedge clk_in) guard_n_in <= 1'b0;
    frame(0, '{OP_WREN}, 0, 9);
    frame(0, '{OP_WRSR, 8'h00}, 0, 9);
    check("guard", status & SR_WR_MASK, 8'h8C);
    @(posedge clk_in) guard_n_in <= 1'b1;
    frame(0, '{OP_WREN}, 0, 9);
    frame(0, '{OP_WRSR, 8'h00}, 0, 9);
    check("sr0", status & SR_WR_MASK, 8'h00);
    frame(0, '{OP_READ, 8'h01, 8'h23}, 1, 9);
    check("prot", rd[0], 8'hA5);
  endtask
  initial begin
    clk_in     = 1'b0;
    sys_rst_in = 1'b1;
    ce_in      = 1'b1;
    guard_n_in = 1'b1;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    t_write_read();
    t_bad();
    t_status();
    end_of_test();
  end
  // watchdog well past the roughly 50 us of traffic
  initial begin
    #200_000;
    bad_count++;
    end_of_test();
  end
endmodule // nvsp_port_tb_top
